// >>> rtl/trap_unit.sv
// Processor trap, reset-instruction and operand semantics unit with AXI4-Lite
// How it works
// RULE1 - A condition-code operator sets flags picked by bits 0-3 when bit 4 is one, else clears them.
// RULE2 - A register source with an auto-adjusted destination uses the register value before adjustment.
// RULE3 - A register source with a deferred auto-adjusted destination also uses the pre-adjust value.
// RULE4 - Moving the program counter as a source stores the instruction address plus two.
// RULE5 - Byte accesses to the odd byte of the status word never raise an odd-address trap.
// RULE6 - The reset instruction leaves the run indicator on.
// RULE7 - Power failure during the reset's bus initialize ends the instruction and takes the power trap.
// RULE8 - An aborted reset still drives bus initialize for at least 300 ns.
// RULE9 - Power failure during the reset fetch is fatal and takes no power-down trap.
// RULE10 - A higher-priority interrupt pre-empts the first instruction of a service routine.
// RULE11 - Service order: bus error, halt, trap instructions, stack overflow, power, bus requests, console stop, wait.
// RULE12 - The reset instruction drives bus initialize for about 20 ms.
// RULE13 - A halt gives control to the console and shows the halt address plus two.
// RULE14 - Flags are carry bit 0, overflow bit 1, zero bit 2, negative bit 3.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`include "trap_unit_cfg.svh"
module trap_unit
    import trap_unit_pkg::*;
#(
    parameter int INIT_CYCLES = `INIT_CYCLES,
    parameter int MIN_INIT_CYCLES = `MIN_INIT_CYCLES
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [15:0] instrAddr,
    input wire operand_req_t opReq,
    input wire logic accValid,
    input wire logic accByte,
    input wire logic [15:0] accAddr,
    input wire logic resetFetch,
    input wire logic resetStart,
    input wire logic powerFail,
    input wire pending_t pendingIn,
    input wire logic continueRun,
    input wire logic intEntry,
    input wire logic [2:0] intNewLevel,
    input wire logic intReqValid,
    input wire logic [2:0] intReqLevel,
    output logic [3:0] flagsOut,
    output logic [15:0] srcOperand,
    output logic oddAddrTrap,
    output logic busInit,
    output logic runLight,
    output logic fatalPower,
    output logic preempt,
    output service_t serviceGrant,
    output logic consoleMode,
    output logic [15:0] consoleData,
    output logic irq
);
    typedef struct packed {
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic consoleStopSw;
        logic [4:0] status;
        logic [4:0] mask;
        logic irq;
        logic [3:0] flags;
        logic [2:0] level;
        logic [15:0] srcOperand;
        logic oddTrap;
        logic consoleMode;
        logic [15:0] consoleData;
        logic runLight;
        reset_phase_t phase;
        logic [31:0] initCount;
        logic busInit;
        logic fatal;
        logic firstPending;
        logic preempt;
        service_t grant;
        logic pfMeta;
        logic pfSync;
    } state_t;

    localparam state_t STATE_RESET = '{phase: RS_IDLE, grant: SV_NONE,
        mask: `MASK_RESET, runLight: 1'b1, default: '0};

    generate
        if (MIN_INIT_CYCLES < 1 || INIT_CYCLES <= MIN_INIT_CYCLES)
            $error("INIT_CYCLES must exceed MIN_INIT_CYCLES, which must be at least one");
    endgenerate

    state_t state_reg;
    state_t state_next;
    logic ccOp;
    logic [3:0] ccFlags;
    logic [15:0] operand;
    pending_t pending;
    service_t grantComb;
    logic writeFire;
    logic readFire;
    logic [4:0] events;
    logic [4:0] w1c;
    logic [31:0] readValue;
    logic readErr;
    logic initLast;
    logic initMinMet;

    cc_operand_unit operandUnit (
        .instrWord(instrWord),
        .instrAddr(instrAddr),
        .flags(state_reg.flags),
        .opReq(opReq),
        .ccOp(ccOp),
        .flagsNext(ccFlags),
        .srcOperand(operand)
    );

    service_arbiter arbiter (
        .pending(pending),
        .grant(grantComb)
    );

    always_comb
    begin
        state_next = state_reg;
        events = 5'h00;
        w1c = 5'h00;
        pending = pendingIn;
        // Power trap while idle; a fatal power loss never requests one
        pending.powerLossTrap = state_reg.pfSync && !state_reg.fatal
            && state_reg.phase == RS_IDLE && !resetFetch; // RULE9
        pending.consoleStop = pendingIn.consoleStop || state_reg.consoleStopSw;
        writeFire = state_reg.awReady && state_reg.wReady;
        readFire = state_reg.arReady;
        initLast = state_reg.initCount == 32'(INIT_CYCLES - 1);
        initMinMet = state_reg.initCount >= 32'(MIN_INIT_CYCLES - 1);

        state_next.pfMeta = powerFail;
        state_next.pfSync = state_reg.pfMeta;

        // Write channel: address and data are both taken in one cycle
        state_next.awReady = s_axi_awvalid && s_axi_wvalid && !state_reg.awReady
            && !state_reg.bValid;
        state_next.wReady = state_next.awReady;
        if (state_reg.bValid && s_axi_bready)
            state_next.bValid = 1'b0;
        if (writeFire)
        begin
            state_next.bValid = 1'b1;
            state_next.bResp = `RESP_OKAY;
            unique case (s_axi_awaddr)
                `CTRL_OFFSET:
                    if (s_axi_wstrb[0])
                        state_next.consoleStopSw = s_axi_wdata[0];
                `STATUS_OFFSET:
                    if (s_axi_wstrb[0])
                        w1c = s_axi_wdata[4:0];
                `MASK_OFFSET:
                    if (s_axi_wstrb[0])
                        state_next.mask = s_axi_wdata[4:0];
                `PSW_OFFSET, `CONSOLE_OFFSET:
                    state_next.bResp = `RESP_OKAY;
                default:
                    state_next.bResp = `RESP_SLVERR;
            endcase
        end

        // Read channel; the odd status byte has no bits and reads zero
        readErr = 1'b0;
        unique case (s_axi_araddr)
            `CTRL_OFFSET: readValue = {31'h0, state_reg.consoleStopSw};
            `STATUS_OFFSET: readValue = {27'h0, state_reg.status};
            `MASK_OFFSET: readValue = {27'h0, state_reg.mask};
            `PSW_OFFSET: readValue = {24'h0, state_reg.level, 1'b0, state_reg.flags};
            `CONSOLE_OFFSET: readValue = {16'h0, state_reg.consoleData};
            default:
            begin
                readValue = 32'h0;
                readErr = 1'b1;
            end
        endcase
        state_next.arReady = s_axi_arvalid && !state_reg.arReady && !state_reg.rValid;
        if (state_reg.rValid && s_axi_rready)
            state_next.rValid = 1'b0;
        if (readFire)
        begin
            state_next.rValid = 1'b1;
            state_next.rData = readValue;
            state_next.rResp = readErr ? `RESP_SLVERR : `RESP_OKAY;
        end

        // Instruction-level operand and flag work
        if (instrValid)
        begin
            state_next.flags = ccFlags; // RULE1
            state_next.srcOperand = operand; // RULE2 RULE4
        end
        // Only word accesses to odd addresses trap; byte accesses never do
        state_next.oddTrap = accValid && accAddr[0] && !accByte; // RULE5

        // Reset instruction sequence; the run light is left untouched
        unique case (state_reg.phase)
            RS_IDLE:
                if (resetFetch && state_reg.pfSync)
                begin
                    state_next.fatal = 1'b1; // RULE9
                    events[`EV_FATAL] = 1'b1;
                end
                else if (resetStart && !state_reg.fatal)
                begin
                    state_next.phase = RS_INIT; // RULE12 RULE6
                    state_next.initCount = 32'h0;
                    state_next.busInit = 1'b1;
                end
            RS_INIT:
            begin
                state_next.initCount = state_reg.initCount + 32'h1;
                if (state_reg.pfSync && initMinMet)
                begin
                    state_next.phase = RS_IDLE; // RULE7
                    state_next.busInit = 1'b0;
                end
                else if (state_reg.pfSync)
                    state_next.phase = RS_ABORT; // RULE8
                else if (initLast)
                begin
                    state_next.phase = RS_IDLE; // RULE12
                    state_next.busInit = 1'b0;
                    events[`EV_INIT_DONE] = 1'b1;
                end
            end
            RS_ABORT:
            begin
                state_next.initCount = state_reg.initCount + 32'h1;
                if (initMinMet)
                begin
                    state_next.phase = RS_IDLE; // RULE8
                    state_next.busInit = 1'b0;
                end
            end
        endcase

        // Interrupt entry: a higher request before the first instruction wins
        state_next.preempt = 1'b0;
        if (intEntry)
        begin
            state_next.level = intNewLevel;
            state_next.firstPending = 1'b1;
        end
        else if (state_reg.firstPending && intReqValid && intReqLevel > state_reg.level)
        begin
            state_next.preempt = 1'b1; // RULE10
            state_next.level = intReqLevel;
            events[`EV_PREEMPT] = 1'b1;
        end
        else if (state_reg.firstPending && instrValid)
            state_next.firstPending = 1'b0;

        // Service selection and its effects
        state_next.grant = grantComb; // RULE11
        if (grantComb == SV_POWER)
            events[`EV_POWER_TRAP] = 1'b1; // RULE7
        if (grantComb == SV_HALT && !state_reg.consoleMode)
        begin
            state_next.consoleMode = 1'b1; // RULE13
            state_next.consoleData = plusTwo(instrAddr); // RULE13
            state_next.runLight = 1'b0;
            events[`EV_HALT] = 1'b1;
        end
        else if (continueRun && state_reg.consoleMode)
        begin
            state_next.consoleMode = 1'b0;
            state_next.runLight = 1'b1;
        end

        // New events win over a clear in the same cycle
        state_next.status = (state_reg.status & ~w1c) | events;
        state_next.irq = |(state_next.status & state_next.mask);
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            state_reg <= STATE_RESET;
        else
            state_reg <= state_next;
    end

    assign s_axi_awready = state_reg.awReady;
    assign s_axi_wready = state_reg.wReady;
    assign s_axi_bvalid = state_reg.bValid;
    assign s_axi_bresp = state_reg.bResp;
    assign s_axi_arready = state_reg.arReady;
    assign s_axi_rvalid = state_reg.rValid;
    assign s_axi_rresp = state_reg.rResp;
    assign s_axi_rdata = state_reg.rData;
    assign flagsOut = state_reg.flags;
    assign srcOperand = state_reg.srcOperand;
    assign oddAddrTrap = state_reg.oddTrap;
    assign busInit = state_reg.busInit;
    assign runLight = state_reg.runLight;
    assign fatalPower = state_reg.fatal;
    assign preempt = state_reg.preempt;
    assign serviceGrant = state_reg.grant;
    assign consoleMode = state_reg.consoleMode;
    assign consoleData = state_reg.consoleData;
    assign irq = state_reg.irq;

    cc_set_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE1
        instrValid && ccOp && instrWord[4] |=> (flagsOut & $past(instrWord[3:0]))
        == $past(instrWord[3:0]))
        else $error("selected flags not set");
    cc_clear_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE1
        instrValid && ccOp && !instrWord[4] |=> (flagsOut & $past(instrWord[3:0])) == 4'h0)
        else $error("selected flags not cleared");
    pre_adjust_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE2
        instrValid && opReq.srcMode == 3'h0 && opReq.srcReg != `PC_REG
        |=> srcOperand == $past(opReq.regPre))
        else $error("source not taken before adjustment");
    pc_plus_two_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE4
        instrValid && opReq.srcMode == 3'h0 && opReq.srcReg == `PC_REG
        |=> srcOperand == $past(instrAddr) + 16'h0002)
        else $error("program counter source not address plus two");
    byte_no_trap_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE5
        accValid && accByte |=> !oddAddrTrap)
        else $error("byte access raised odd-address trap");
    run_kept_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE6
        runLight && !consoleMode && state_reg.phase == RS_INIT |=> runLight)
        else $error("reset instruction cleared run light");
    init_min_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE8
        $fell(busInit) |-> $past(state_reg.initCount) >= 32'(MIN_INIT_CYCLES - 1))
        else $error("bus initialize shorter than minimum");
    abort_fast_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE7
        state_reg.phase == RS_INIT && state_reg.pfSync && initMinMet |=> !busInit
        ##1 (serviceGrant inside {[SV_BUS_ERROR:SV_POWER]} || !$past(state_reg.pfSync)))
        else $error("power loss did not end reset instruction");
    fatal_quiet_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE9
        fatalPower |-> serviceGrant != SV_POWER)
        else $error("power trap after fatal power loss");
    preempt_first_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE10
        state_reg.firstPending && !intEntry && intReqValid && intReqLevel > state_reg.level
        |=> preempt)
        else $error("higher interrupt did not pre-empt");
    order_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE11
        pendingIn.busError |=> serviceGrant == SV_BUS_ERROR)
        else $error("bus error not serviced first");
    halt_console_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE13
        grantComb == SV_HALT && !consoleMode
        |=> consoleMode && consoleData == $past(instrAddr) + 16'h0002)
        else $error("halt did not show next address");
endmodule : trap_unit

// >>> rtl/trap_unit_cfg.svh
// Offsets, field positions, reset values and timing counts of the trap unit
`ifndef TRAP_UNIT_CFG_SVH
`define TRAP_UNIT_CFG_SVH
`define CLK_PERIOD_NS 10
`define INIT_TIME_NS 20000000
`define INIT_CYCLES (`INIT_TIME_NS / `CLK_PERIOD_NS)
`define MIN_INIT_NS 300
`define MIN_INIT_CYCLES ((`MIN_INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define MASK_OFFSET 8'h08
`define PSW_OFFSET 8'h0c
`define CONSOLE_OFFSET 8'h10
`define CTRL_RESET 32'h0000_0000
`define MASK_RESET 5'h00
`define EV_INIT_DONE 0
`define EV_POWER_TRAP 1
`define EV_FATAL 2
`define EV_HALT 3
`define EV_PREEMPT 4
`define CC_SET_BIT 4
`define CC_OP_PREFIX 11'h005
`define PC_REG 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> rtl/trap_unit_pkg.sv
// Types shared by the trap unit and its helpers
package trap_unit_pkg;
    typedef enum logic [3:0] {SV_NONE, SV_BUS_ERROR, SV_HALT, SV_TRAP_INSTR,
        SV_STACK_OVF, SV_POWER, SV_BUS_REQ, SV_CONSOLE_STOP, SV_WAIT} service_t;
    typedef enum logic [1:0] {RS_IDLE, RS_INIT, RS_ABORT} reset_phase_t;
    typedef struct packed {
        logic busError;
        logic haltInstr;
        logic trapInstr;
        logic stackOverflowTrap;
        logic powerLossTrap;
        logic busRequest;
        logic consoleStop;
        logic waitLoop;
    } pending_t;
    typedef struct packed {
        logic [2:0] srcMode;
        logic [2:0] srcReg;
        logic [15:0] regPre;
        logic [15:0] memOperand;
    } operand_req_t;

    function automatic logic [15:0] plusTwo(input logic [15:0] addr);
        plusTwo = addr + 16'h0002;
    endfunction : plusTwo
endpackage : trap_unit_pkg

// >>> rtl/service_arbiter.sv
// Fixed-order selection among pending processor service conditions
module service_arbiter
    import trap_unit_pkg::*;
(
    input wire pending_t pending,
    output service_t grant
);
    always_comb
    begin
        if (pending.busError)
            grant = SV_BUS_ERROR; // RULE11
        else if (pending.haltInstr)
            grant = SV_HALT;
        else if (pending.trapInstr)
            grant = SV_TRAP_INSTR;
        else if (pending.stackOverflowTrap)
            grant = SV_STACK_OVF;
        else if (pending.powerLossTrap)
            grant = SV_POWER;
        else if (pending.busRequest)
            grant = SV_BUS_REQ;
        else if (pending.consoleStop)
            grant = SV_CONSOLE_STOP;
        else if (pending.waitLoop)
            grant = SV_WAIT;
        else
            grant = SV_NONE;
    end
endmodule : service_arbiter

// >>> rtl/cc_operand_unit.sv
// Condition-code operator and source operand selection
`include "trap_unit_cfg.svh"
module cc_operand_unit
    import trap_unit_pkg::*;
(
    input wire logic [15:0] instrWord,
    input wire logic [15:0] instrAddr,
    input wire logic [3:0] flags,
    input wire operand_req_t opReq,
    output logic ccOp,
    output logic [3:0] flagsNext,
    output logic [15:0] srcOperand
);
    always_comb
    begin
        ccOp = instrWord[15:5] == `CC_OP_PREFIX;
        flagsNext = flags;
        if (ccOp)
        begin
            if (instrWord[`CC_SET_BIT])
                flagsNext = flags | instrWord[3:0]; // RULE1 RULE14
            else
                flagsNext = flags & ~instrWord[3:0]; // RULE1
        end
        // Register operands other than the PC use the value read before any adjustment
        if (opReq.srcMode != 3'h0)
            srcOperand = opReq.memOperand;
        else if (opReq.srcReg == `PC_REG)
            srcOperand = plusTwo(instrAddr); // RULE4
        else
            srcOperand = opReq.regPre; // RULE2 RULE3
    end
endmodule : cc_operand_unit

// >>> tb/bus_device_model.sv
// Behavioural system-bus peripheral that asks for the bus and is reset by bus initialize
module bus_device_model
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic busInit,
    input wire logic wantReq,
    output logic busReq
);
    timeunit 1ns;
    timeprecision 1ps;
    // Initialize holds the device at power-up state, so its request is withdrawn while initialize lasts
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            busReq <= 1'b0;
        else
            busReq <= wantReq && !busInit;
    end
endmodule : bus_device_model

// >>> tb/trap_unit_tb_top.sv
// Self-checking bench for the trap unit
module trap_unit_tb_top
    import trap_unit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_b = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp, rsp;
    logic instrValid = 0, accValid = 0, accByte = 0, resetFetch = 0, resetStart = 0;
    logic powerFail = 0, continueRun = 0, intEntry = 0, intReqValid = 0, wantReq = 0;
    logic [15:0] instrWord = 0, instrAddr = 0, accAddr = 0, srcOperand, consoleData;
    logic [2:0] intNewLevel = 0, intReqLevel = 0;
    operand_req_t opReq = '0;
    pending_t pendTb = '0, pendingIn;
    logic [3:0] flagsOut, fl;
    logic oddAddrTrap, busInit, runLight, fatalPower, preempt, consoleMode, irq, busReq;
    logic sawPower;
    service_t serviceGrant;
    int num_errors = 0, n_tests = 0, n;
    logic [15:0] codes [13] = '{16'h00bf, 16'h00a1, 16'h00a2, 16'h00b1, 16'h00a4, 16'h00a8,
        16'h00b4, 16'h00b2, 16'h00b8, 16'h00b0, 16'h00a3, 16'h00af, 16'h00a0};
    assign pendingIn = pendTb | pending_t'({5'h00, busReq, 2'h0});
    trap_unit #(.INIT_CYCLES(100), .MIN_INIT_CYCLES(30)) trap_unit_i (.clock(clock),
        .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .instrValid(instrValid), .instrWord(instrWord), .instrAddr(instrAddr), .opReq(opReq),
        .accValid(accValid), .accByte(accByte), .accAddr(accAddr), .resetFetch(resetFetch),
        .resetStart(resetStart), .powerFail(powerFail), .pendingIn(pendingIn),
        .continueRun(continueRun), .intEntry(intEntry), .intNewLevel(intNewLevel),
        .intReqValid(intReqValid), .intReqLevel(intReqLevel), .flagsOut(flagsOut),
        .srcOperand(srcOperand), .oddAddrTrap(oddAddrTrap), .busInit(busInit),
        .runLight(runLight), .fatalPower(fatalPower), .preempt(preempt),
        .serviceGrant(serviceGrant), .consoleMode(consoleMode), .consoleData(consoleData),
        .irq(irq));
    bus_device_model bus_device_model_i (.clock(clock), .rst_b(rst_b), .busInit(busInit),
        .wantReq(wantReq), .busReq(busReq));
    initial
    begin
        forever #5 clock = ~clock;
    end
    task tick(input int k);
        repeat (k) @(posedge clock);
    endtask : tick
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            num_errors++;
        end
    endtask : check
    // Valids and payload stay put until their own ready edge
    task axiWrite(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (awvalid || wvalid || bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge clock);
    endtask : axiWrite
    task axiRead(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (arvalid || rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask : axiRead
    task exec(input logic [15:0] w, input logic [15:0] a, input operand_req_t q);
        instrWord <= w;
        instrAddr <= a;
        opReq <= q;
        instrValid <= 1'b1;
        @(posedge clock);
        instrValid <= 1'b0;
        @(posedge clock);
    endtask : exec
    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        tick(20000);
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        tick(2);
        rst_b <= 1'b1;
        @(posedge clock);
        fl = 4'h0;
        foreach (codes[i])
        begin
            exec(codes[i], 16'h0100, '0);
            fl = codes[i][4] ? (fl | codes[i][3:0]) : (fl & ~codes[i][3:0]);
            check("flags", flagsOut, fl);
        end
        axiRead(8'h0c);
        check("psw", rd[15:0], {12'h000, fl});
        $display("test cc done");
        exec(16'h1010, 16'h0100, '{3'h0, 3'h0, 16'h0064, 16'h1234});
        check("src autoinc", srcOperand, 16'h0064);
        exec(16'h1018, 16'h0100, '{3'h0, 3'h0, 16'h0064, 16'h1234});
        check("src deferred", srcOperand, 16'h0064);
        exec(16'h11df, 16'h0200, '{3'h0, 3'h7, 16'h0000, 16'h1234});
        check("pc source", srcOperand, 16'h0202);
        $display("test operand done");
        // Byte to the odd status byte, then a word at an odd address for contrast
        for (int b = 1; b >= 0; b--)
        begin
            accAddr <= 16'hff77;
            accByte <= b[0];
            accValid <= 1'b1;
            @(posedge clock);
            accValid <= 1'b0;
            tick(1);
            check("odd trap", oddAddrTrap, !b[0]);
        end
        $display("test odd done");
        resetStart <= 1'b1;
        @(posedge clock);
        resetStart <= 1'b0;
        n = 0;
        repeat (200)
        begin
            @(posedge clock);
            if (busInit === 1'b1) n++;
            if (n == 50) check("run light", runLight, 1'b1);
        end
        check("init cycles", n, 100);
        axiRead(8'h04);
        check("init done", rd[0], 1'b1);
        axiWrite(8'h04, 32'h0000_001f);
        $display("test reset done");
        for (int d = 0; d <= 40; d += 40)
        begin
            resetStart <= 1'b1;
            @(posedge clock);
            resetStart <= 1'b0;
            n = 0;
            sawPower = 1'b0;
            for (int k = 0; k < 80; k++)
            begin
                @(posedge clock);
                if (k == d) powerFail <= 1'b1;
                if (busInit === 1'b1) n++;
                if (serviceGrant === SV_POWER) sawPower = 1'b1;
            end
            check("abort short", n < 100, 1'b1);
            check("abort minimum", n >= 30, 1'b1);
            check("power grant", sawPower, 1'b1);
            axiRead(8'h04);
            check("power status", rd[1], 1'b1);
            powerFail <= 1'b0;
            tick(5);
            axiWrite(8'h04, 32'h0000_001f);
        end
        $display("test abort done");
        for (int i = 0; i < 8; i++)
        begin
            pendTb <= pending_t'(8'hff >> i);
            wantReq <= (i <= 5);
            powerFail <= (i == 4);
            tick(4);
            check("grant", serviceGrant, service_t'(i + 1));
        end
        pendTb <= pending_t'(8'h40);
        wantReq <= 1'b0;
        tick(4);
        pendTb <= '0;
        check("console mode", consoleMode, 1'b1);
        check("console data", consoleData, 16'h0202);
        continueRun <= 1'b1;
        @(posedge clock);
        continueRun <= 1'b0;
        tick(2);
        check("continue", runLight, 1'b1);
        $display("test order done");
        axiWrite(8'h04, 32'h0000_001f);
        axiWrite(8'h08, 32'h0000_0010);
        for (int lv = 3; lv <= 6; lv += 3)
        begin
            intNewLevel <= 3'h4;
            intEntry <= 1'b1;
            @(posedge clock);
            intEntry <= 1'b0;
            intReqLevel <= lv[2:0];
            intReqValid <= 1'b1;
            @(posedge clock);
            intReqValid <= 1'b0;
            tick(1);
            check("preempt", preempt, lv > 4);
            exec(16'h00a0, 16'h0300, '0);
        end
        tick(2);
        check("irq set", irq, 1'b1);
        axiWrite(8'h04, 32'h0000_0010);
        tick(2);
        check("irq clear", irq, 1'b0);
        axiRead(8'h40);
        check("unmapped", rsp, 2'h2);
        $display("test interrupt done");
        // Power lost during the fetch: sticky fatal, and never a power-down trap
        powerFail <= 1'b1;
        tick(2);
        resetFetch <= 1'b1;
        @(posedge clock);
        resetFetch <= 1'b0;
        tick(2);
        check("fatal", fatalPower, 1'b1);
        resetStart <= 1'b1;
        @(posedge clock);
        resetStart <= 1'b0;
        tick(40);
        check("no power grant", serviceGrant !== SV_POWER, 1'b1);
        axiRead(8'h04);
        check("no power trap", rd[1], 1'b0);
        powerFail <= 1'b0;
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        tick(1);
        check("fatal cleared", fatalPower, 1'b0);
        $display("test fatal done");
        tally_and_finish();
    end
endmodule : trap_unit_tb_top
